// *** slsr_defs.svh ***
// Purpose: Register offsets, field positions and reset values of the sync word and request block
// Assumes: Byte-addressed Avalon-MM, one 32-bit word per register
// Notes:   Byte addresses with full decode; the mode register sits at an odd address
`ifndef SLSR_DEFS_SVH
`define SLSR_DEFS_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define SLSR_OFS_MODE        12'h20f
`define SLSR_OFS_THRESH      12'h210
`define SLSR_OFS_LINK_CTRL   12'h214
`define SLSR_OFS_STATUS      12'h218

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define SLSR_MODE_MSB        1
`define SLSR_THRESH_MSB      4
`define SLSR_MODE_RST        2'h0
`define SLSR_THRESH_RST      5'h03
`define SLSR_CTRL_EN_BIT     0
`define SLSR_CTRL_66B_BIT    1
`define SLSR_STAT_LEVEL_BIT  0
`define SLSR_STAT_REQ_BIT    1
`define SLSR_STAT_ERR_BIT    2

`endif

// *** slsr_pkg.sv ***
// Purpose: Types of the sync word and request block
// Assumes: Constants live in slsr_defs.svh
// Notes:   None
package slsr_pkg;
  typedef enum logic [1:0] {
    SLSR_PAY_CRC12 = 2'b00,
    SLSR_PAY_RSVD1 = 2'b01,
    SLSR_PAY_FEC   = 2'b10,
    SLSR_PAY_RSVD3 = 2'b11
  } slsr_payload_t;

  typedef enum logic [1:0] {
    SLSR_ST_IDLE  = 2'b00,
    SLSR_ST_COUNT = 2'b01,
    SLSR_ST_REQ   = 2'b10
  } slsr_state_t;
endpackage

// *** slsr_top.sv ***
// Purpose: Sync word payload select and filter of the active-low sync request
// Assumes: clk_in is the link clock; sync_n_in is asynchronous to it
// Notes:   Avalon-MM slave, answers one cycle after the request
`include "slsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module slsr_top #(
  parameter int SYNC_WORD_W = 32
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic [11:0]              avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic      [31:0]              avs_readdata_out,
  output logic                          avs_waitrequest_out,
  output logic      [1:0]               avs_response_out,
  input  wire logic                     sync_n_in,
  input  wire logic [SYNC_WORD_W-1:0]   crc_word_in,
  input  wire logic [SYNC_WORD_W-1:0]   fec_word_in,
  output logic      [SYNC_WORD_W-1:0]   sync_word_out,
  output logic      [SYNC_WORD_W-1:0]   cmd_field_out,
  output logic                          link_enable_out,
  output slsr_pkg::slsr_payload_t       sync_header_payload_sel_out,
  output logic                          sync_request_out,
  output logic                          sync_error_out
);
  import slsr_pkg::*;

  // ========================================================================
  // Elaboration checks
  // ========================================================================
  // Sync word holds exactly 32 data bits per multiblock
  if (SYNC_WORD_W != 32) begin : g_bad_word_w
    $error("SYNC_WORD_W must be 32");
  end

  // ========================================================================
  // Registers
  // ========================================================================
  logic [`SLSR_MODE_MSB:0]   mode_reg;
  logic [`SLSR_THRESH_MSB:0] thresh_reg;
  logic                      enable_reg;
  logic                      link_66b_reg;
  logic                      ack_reg;
  logic [31:0]               rdata_reg;
  logic [1:0]                resp_reg;
  logic [2:0]                sync_sh_reg;
  logic                      level_reg;
  logic [4:0]                low_cnt_reg;
  logic                      error_reg;
  slsr_state_t               state_reg;
  slsr_state_t               state_next;
  logic [SYNC_WORD_W-1:0]    word_reg;
  // Next values
  logic                      ack_next;
  logic [31:0]               rdata_next;
  logic [1:0]                resp_next;
  logic                      level_next;
  logic [4:0]                low_cnt_next;
  logic                      error_next;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ========================================================================
  // Bus decode
  // ========================================================================
  wire logic req_w      = (avs_read_in | avs_write_in) & ~ack_reg;
  wire logic sel_mode   = hit(avs_address_in, `SLSR_OFS_MODE);
  wire logic sel_thresh = hit(avs_address_in, `SLSR_OFS_THRESH);
  wire logic sel_ctrl   = hit(avs_address_in, `SLSR_OFS_LINK_CTRL);
  wire logic sel_stat   = hit(avs_address_in, `SLSR_OFS_STATUS);
  wire logic mapped     = sel_mode | sel_thresh | sel_ctrl | sel_stat;
  // Write lands at the edge where waitrequest is seen low
  wire logic wr_ok      = ack_reg & avs_write_in & avs_byteenable_in[0];
  // status bit 0 shows filtered level
  wire logic [31:0] rd_mux =
      sel_mode   ? {30'h0, mode_reg} :
      sel_thresh ? {27'h0, thresh_reg} :
      sel_ctrl   ? {30'h0, link_66b_reg, enable_reg} :
      sel_stat   ? {29'h0, error_reg, sync_request_out, level_reg} : 32'h0;

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;
  assign avs_response_out    = resp_reg;

  // Read data and response captured while waitrequest is high
  assign ack_next   = req_w;
  assign rdata_next = (req_w & avs_read_in) ? rd_mux : rdata_reg;
  assign resp_next  = req_w ? (mapped ? 2'h0 : 2'h2) : resp_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
      resp_reg  <= 2'h0;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg     <= `SLSR_MODE_RST;
      thresh_reg   <= `SLSR_THRESH_RST;
      enable_reg   <= 1'b0;
      link_66b_reg <= 1'b0;
    end else if (wr_ok) begin
      if (sel_mode) begin
        mode_reg <= avs_writedata_in[`SLSR_MODE_MSB:0];
      end
      if (sel_thresh) begin
        thresh_reg <= avs_writedata_in[`SLSR_THRESH_MSB:0];
      end
      if (sel_ctrl) begin
        enable_reg   <= avs_writedata_in[`SLSR_CTRL_EN_BIT];
        link_66b_reg <= avs_writedata_in[`SLSR_CTRL_66B_BIT];
      end
    end
  end

  // ========================================================================
  // Sync request filter
  // ========================================================================
  // three-stage sampler, change on agreement
  wire logic [2:0] sync_sh_next;
  assign sync_sh_next[0] = sync_n_in;
  // Stages 1 and 2 each read only the one before it
  for (genvar i = 1; i < 3; i++) begin : g_sync_stage
    assign sync_sh_next[i] = sync_sh_reg[i-1];
  end
  // Single-sample glitches never reach the level
  wire logic stages_agree = (sync_sh_reg[1] == sync_sh_reg[2]);
  assign level_next = stages_agree ? sync_sh_reg[2] : level_reg;

  // Idle level is high, so no false request after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_sh_reg <= 3'b111;
      level_reg   <= 1'b1;
    end else begin
      sync_sh_reg <= sync_sh_next;
      level_reg   <= level_next;
    end
  end

  // Run length reached once count meets threshold
  wire logic limit_hit = (low_cnt_reg >= thresh_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLSR_ST_IDLE: begin
        if (enable_reg && !level_reg) begin
          state_next = (thresh_reg == 5'h0) ? SLSR_ST_REQ : SLSR_ST_COUNT;
        end
      end
      SLSR_ST_COUNT: begin
        if (level_reg || !enable_reg) begin
          state_next = SLSR_ST_IDLE;
        end else if (limit_hit) begin
          state_next = SLSR_ST_REQ;
        end
      end
      SLSR_ST_REQ: begin
        if (level_reg || !enable_reg) begin
          state_next = SLSR_ST_IDLE;
        end
      end
      default: begin
        state_next = SLSR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg   <= SLSR_ST_IDLE;
      low_cnt_reg <= 5'h0;
      error_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      low_cnt_reg <= low_cnt_next;
      error_reg   <= error_next;
    end
  end

  // Counter runs only while counting; any break clears it
  assign low_cnt_next = (state_next == SLSR_ST_COUNT) ? low_cnt_reg + 5'h1 : 5'h0;
  assign error_next   = (state_reg == SLSR_ST_COUNT) & level_reg;

  assign sync_request_out = (state_reg == SLSR_ST_REQ);
  assign sync_error_out   = error_reg;

  // ========================================================================
  // Sync word payload
  // ========================================================================
  // payload select in 64B/66B only
  wire logic [SYNC_WORD_W-1:0] word_sel =
      !link_66b_reg             ? {SYNC_WORD_W{1'b0}} :
      (mode_reg == SLSR_PAY_FEC) ? fec_word_in : crc_word_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_reg <= {SYNC_WORD_W{1'b0}};
    end else begin
      word_reg <= word_sel;
    end
  end

  assign sync_word_out               = word_reg;
  assign cmd_field_out               = {SYNC_WORD_W{1'b0}};
  assign link_enable_out             = enable_reg;
  assign sync_header_payload_sel_out = slsr_payload_t'(mode_reg);

endmodule // slsr_top
`default_nettype wire

// *** slsr_assertions.sv ***
// Purpose: Port checks of the sync word and request block
// Assumes: Bench holds payload words distinct and nonzero
// Notes:   Bound into slsr_top
`timescale 1ns/1ps
`default_nettype none
module slsr_assertions
  import slsr_pkg::*;
#(
  parameter int SYNC_WORD_W = 32
) (
  input wire logic                   clk_in,
  input wire logic                   rst_in,
  input wire logic                   avs_write_in,
  input wire logic                   sync_n_in,
  input wire logic [SYNC_WORD_W-1:0] crc_word_in,
  input wire logic [SYNC_WORD_W-1:0] fec_word_in,
  input wire logic [SYNC_WORD_W-1:0] sync_word_out,
  input wire logic [SYNC_WORD_W-1:0] cmd_field_out,
  input wire logic                   link_enable_out,
  input wire logic [1:0]             sync_header_payload_sel_out,
  input wire logic                   sync_request_out,
  input wire logic                   sync_error_out
);
  // ====
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  cmd_idle_a: assert property (cmd_field_out == '0)
    else $error("command field not idle");
  fec_word_a: assert property ((sync_header_payload_sel_out == SLSR_PAY_FEC) && $stable(sync_header_payload_sel_out)
    && (sync_word_out != '0) |-> sync_word_out == $past(fec_word_in)) else $error("fec word wrong");
  crc_word_a: assert property ((sync_header_payload_sel_out != SLSR_PAY_FEC) && $stable(sync_header_payload_sel_out)
    && (sync_word_out != '0) |-> sync_word_out == $past(crc_word_in)) else $error("crc word wrong");
  sel_by_write_a: assert property (!$stable(sync_header_payload_sel_out) |-> $past(avs_write_in))
    else $error("mode changed without write");
  off_no_req_a: assert property (!link_enable_out ##1 !link_enable_out |-> !sync_request_out)
    else $error("request while disabled");
  rise_enabled_a: assert property ($rose(sync_request_out) |-> $past(link_enable_out))
    else $error("request rose while disabled");
  req_hold_a: assert property ((!sync_n_in)[*6] ##0 (sync_request_out && link_enable_out) |=> sync_request_out)
    else $error("request dropped while low");
  err_no_req_a: assert property (sync_error_out |-> !sync_request_out)
    else $error("error with request");
  err_pulse_a: assert property (sync_error_out |=> !sync_error_out)
    else $error("error pulse too long");
  cover property ($rose(sync_request_out));
  cover property (sync_error_out);
  cover property ((sync_header_payload_sel_out == SLSR_PAY_FEC) && (sync_word_out != '0));
endmodule // slsr_assertions
bind slsr_top slsr_assertions #(.SYNC_WORD_W(SYNC_WORD_W)) chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .avs_write_in(avs_write_in), .sync_n_in(sync_n_in), .crc_word_in(crc_word_in), .fec_word_in(fec_word_in),
  .sync_word_out(sync_word_out), .cmd_field_out(cmd_field_out), .link_enable_out(link_enable_out),
  .sync_header_payload_sel_out(sync_header_payload_sel_out), .sync_request_out(sync_request_out),
  .sync_error_out(sync_error_out));
`default_nettype wire

// *** slsr_rx_model.sv ***
// Purpose: Far-end receiver driving the active-low request
// Assumes: Line idles high through its pull-up
// Notes:   Low run of the commanded length
`timescale 1ns/1ps
`default_nettype none
module slsr_rx_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] low_len_in,
  input  wire logic       go_in,
  output logic            sync_n_out
);
  // ====
  // Low run counter
  logic [7:0] left_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) left_reg <= 8'h00;
    else if (go_in) left_reg <= low_len_in;
    else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
  end
  assign sync_n_out = (left_reg == 8'h00);
endmodule // slsr_rx_model
`default_nettype wire

// *** slsr_top_tb_top.sv ***
// Purpose: Self-checking bench of the sync word and request block
// Assumes: Bus waits on waitrequest
// Notes:   Payload sources are fixed words
`include "slsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module slsr_top_tb_top;
  import slsr_pkg::*;
  localparam logic [31:0] CRC = 32'hc3c3_0a12;
  localparam logic [31:0] FEC = 32'h5e5e_f0c2;
  logic        clk_in = 0, rst_in = 1, rd_r = 0, wr_r = 0, go = 0, rs = 0, es = 0;
  logic        sync_n, wreq, req, err, en_o;
  logic [11:0] adr = '0;
  logic [31:0] wd = '0, rdata, word, q, cmd;
  logic [1:0]  rsp, sel_o;
  logic [7:0]  len = '0;
  int          fails = 0, n_tests = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  slsr_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd_r),
    .avs_write_in(wr_r), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .avs_response_out(rsp), .sync_n_in(sync_n), .crc_word_in(CRC),
    .fec_word_in(FEC), .sync_word_out(word), .cmd_field_out(cmd), .link_enable_out(en_o),
    .sync_header_payload_sel_out(sel_o), .sync_request_out(req), .sync_error_out(err));
  slsr_rx_model rx_u (.clk_in(clk_in), .rst_in(rst_in), .low_len_in(len), .go_in(go), .sync_n_out(sync_n));
  // ====
  // Tasks
  task automatic print_verdict();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (req === 1'b1) rs <= 1;
    if (err === 1'b1) es <= 1;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd_r <= !w;
    wr_r <= w;
    @(posedge clk_in);
    while (wreq !== 1'b0) @(posedge clk_in);
    q = rdata;
    rd_r <= 0;
    wr_r <= 0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(a, 0, '0);
    chk(q, e);
  endtask
  task automatic pulse(input logic [7:0] n, input int w);
    @(posedge clk_in);
    len <= n;
    go <= 1;
    rs <= 0;
    es <= 0;
    @(posedge clk_in);
    go <= 0;
    repeat (w) @(posedge clk_in);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    rd(`SLSR_OFS_THRESH, 32'h3);
    rd(`SLSR_OFS_MODE, 32'h0);
    rd(12'h300, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    bus(`SLSR_OFS_LINK_CTRL, 1, 32'h2);
    repeat (3) @(posedge clk_in);
    chk(word, CRC);
    chk(cmd, 32'h0);
    bus(`SLSR_OFS_MODE, 1, 32'h2);
    rd(`SLSR_OFS_MODE, 32'h2);
    chk({30'h0, sel_o}, 32'h2);
    chk(word, FEC);
    bus(`SLSR_OFS_LINK_CTRL, 1, 32'h0);
    repeat (3) @(posedge clk_in);
    chk(word, 32'h0);
    bus(`SLSR_OFS_THRESH, 1, 32'h5);
    bus(`SLSR_OFS_LINK_CTRL, 1, 32'h3);
    chk({31'h0, en_o}, 32'h1);
    pulse(5, 15);
    chk(rs, 0);
    chk(es, 1);
    pulse(6, 15);
    chk(rs, 1);
    pulse(4, 8);
    pulse(4, 15);
    chk(rs, 0);
    pulse(60, 20);
    rd(`SLSR_OFS_STATUS, 32'h2);
    repeat (50) @(posedge clk_in);
    rd(`SLSR_OFS_STATUS, 32'h1);
    chk(req, 0);
    bus(`SLSR_OFS_LINK_CTRL, 1, 32'h2);
    bus(`SLSR_OFS_THRESH, 1, 32'h0);
    bus(`SLSR_OFS_LINK_CTRL, 1, 32'h3);
    pulse(2, 15);
    chk(rs, 1);
    bus(`SLSR_OFS_LINK_CTRL, 1, 32'h0);
    pulse(20, 25);
    chk(rs, 0);
    print_verdict();
  end
endmodule // slsr_top_tb_top
`default_nettype wire
